/* src/itc_map.svh */
/*
 * Register offsets, field positions, masks and reset values of the
 * interrupt and trap control block.
 * Assumes byte addresses on a 32-bit Wishbone bus, one word per register.
 */
`ifndef ITC_MAP_SVH
`define ITC_MAP_SVH

// ----------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------
`define ITC_ADR_CTRL_ONE   8'h00
`define ITC_ADR_CTRL_TWO   8'h04
`define ITC_ADR_FLAGS_ZERO 8'h08

// ----------------------------------------------------------------------
// control one fields
// ----------------------------------------------------------------------
`define ITC_C1_NEST_DIS    15
`define ITC_C1_OVF_A       14
`define ITC_C1_OVF_B       13
`define ITC_C1_CAT_A       12
`define ITC_C1_CAT_B       11
`define ITC_C1_OVF_A_EN    10
`define ITC_C1_OVF_B_EN    9
`define ITC_C1_CAT_EN      8
`define ITC_C1_SHIFT_ERR   7
`define ITC_C1_DIV_ZERO    6
`define ITC_C1_DMA_ERR     5
`define ITC_C1_MATH_ERR    4
`define ITC_C1_ADDR_ERR    3
`define ITC_C1_STACK_ERR   2
`define ITC_C1_OSC_FAIL    1

// ----------------------------------------------------------------------
// control two fields
// ----------------------------------------------------------------------
`define ITC_C2_ALT_TABLE   15
`define ITC_C2_DIS_INSTR   14

// ----------------------------------------------------------------------
// masks and reset values
// ----------------------------------------------------------------------
`define ITC_C1_RD_MASK     16'hFFFE
`define ITC_C2_WR_MASK     16'h8007
`define ITC_C2_RD_MASK     16'hC007
`define ITC_FL_RD_MASK     16'h7FFF
`define ITC_REG_RESET      16'h0000
`define ITC_EXT_COUNT      3

`endif

/* src/itc_pkg.sv */
/*
 * Types shared by the interrupt and trap control modules.
 * Assumes itc_map.svh is compiled alongside for the numeric constants.
 */
package itc_pkg;

    // ------------------------------------------------------------------
    // bus handshake states
    // ------------------------------------------------------------------
    typedef enum logic [0:0] {
        ITC_BUS_IDLE = 1'b0,
        ITC_BUS_ACK  = 1'b1
    } itc_bus_st_t;

    typedef logic [15:0] itc_reg_t;

    // ------------------------------------------------------------------
    // whole state of the top module
    // ------------------------------------------------------------------
    typedef struct packed {
        itc_bus_st_t busSt;
        itc_reg_t    rdData;
        itc_reg_t    ctrlOne;
        itc_reg_t    ctrlTwo;
        itc_reg_t    flags;
        logic        mathTrap;
        logic        addrTrap;
        logic        stackTrap;
        logic        oscTrap;
        logic        dmaTrap;
        logic        preemptTake;
        logic [2:1]  extEvent;
    } itc_state_t;

    // ------------------------------------------------------------------
    // state of the external edge detector
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [2:0] prev;
        logic       armed;
    } itc_edge_state_t;

endpackage

/* src/itc_edge_if.sv */
/*
 * Carrier between the top module and the external edge detector.
 * Assumes one clock domain; pins arrive synchronous to clk.
 */
interface itc_edge_if;
    logic [2:0] pin;
    logic [2:0] polarity;
    logic [2:0] edgeSeen;

    modport det (
        input  pin,
        input  polarity,
        output edgeSeen
    );
    modport user (
        output pin,
        output polarity,
        input  edgeSeen
    );
endinterface

/* src/itc_edge_det.sv */
/*
 * Edge detector for the external interrupt pins with per-pin polarity.
 * Assumes pins are already synchronous to clk; edgeSeen is combinational.
 */
`include "itc_map.svh"

module itc_edge_det (
    input wire logic clk,
    input wire logic rstn,
    itc_edge_if.det  edgeBus
);
    itc_pkg::itc_edge_state_t st_q;
    itc_pkg::itc_edge_state_t st_d;

    // ------------------------------------------------------------------
    // edge detection
    // ------------------------------------------------------------------
    // armed blocks a false edge from the reset value of prev
    always_comb begin
        st_d       = st_q;
        st_d.prev  = edgeBus.pin;
        st_d.armed = 1'b1;
    end

    // polarity 1 catches falling, 0 rising
    assign edgeBus.edgeSeen = {`ITC_EXT_COUNT{st_q.armed}} &
        ((edgeBus.polarity & st_q.prev & ~edgeBus.pin) |
         (~edgeBus.polarity & ~st_q.prev & edgeBus.pin));

    // state register
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    sequence sRiseCfg;
        st_q.armed && !edgeBus.polarity[0] && !st_q.prev[0] && edgeBus.pin[0];
    endsequence

    AST_EXT_POL: assert property (@(posedge clk) disable iff (!rstn)
        sRiseCfg |-> edgeBus.edgeSeen[0])
        else $error("rising edge missed with rising polarity");
    AST_EXT_NEG: assert property (@(posedge clk) disable iff (!rstn)
        (edgeBus.polarity[1] && !st_q.prev[1]) |-> !edgeBus.edgeSeen[1])
        else $error("edge reported without a falling transition");
endmodule

/* src/itc_top.sv */
/*
 * Global interrupt and trap control plus the first interrupt flag
 * register, reached over a classic Wishbone slave.
 * Assumes trap and request inputs are one-cycle pulses synchronous to clk,
 * and that the core reports its in-service state and priority levels.
 */
// Design decisions made here: the address map and the Wishbone slave port.
`include "itc_map.svh"

module itc_top (
    input  wire logic        clk,
    input  wire logic        rstn,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic        accAOvfEvt,
    input  wire logic        accBOvfEvt,
    input  wire logic        accACatEvt,
    input  wire logic        accBCatEvt,
    input  wire logic        shiftErrEvt,
    input  wire logic        divZeroEvt,
    input  wire logic        dmaErrEvt,
    input  wire logic        addrErrEvt,
    input  wire logic        stackErrEvt,
    input  wire logic        oscFailEvt,
    input  wire logic        disableInstrActive,
    input  wire logic [14:1] periphReq,
    input  wire logic [2:0]  extPin,
    input  wire logic        pendReq,
    input  wire logic [3:0]  pendLevel,
    input  wire logic [3:0]  cpuLevel,
    input  wire logic        inService,
    output logic             mathTrap,
    output logic             addrTrap,
    output logic             stackTrap,
    output logic             oscTrap,
    output logic             dmaTrap,
    output logic             preemptTake,
    output logic             nestingDisable,
    output logic             levelWriteLock,
    output logic             alternateTableSelect,
    output logic [15:0]      flagsZero,
    output logic [2:1]       extEvent
);
    itc_pkg::itc_state_t st_q;
    itc_pkg::itc_state_t st_d;
    itc_edge_if          edgeBus ();

    logic        reqOn;
    logic        wrCommit;
    logic        wrOne;
    logic        wrTwo;
    logic        wrFlags;
    logic [15:0] laneMask;
    logic [15:0] wrData;
    logic        ovfATake;
    logic        ovfBTake;
    logic        catATake;
    logic        catBTake;
    logic        mathTake;

    // ------------------------------------------------------------------
    // external pin edges
    // ------------------------------------------------------------------
    assign edgeBus.pin      = extPin;
    assign edgeBus.polarity = st_q.ctrlTwo[2:0];

    itc_edge_det edgeUnit (
        .clk     (clk),
        .rstn    (rstn),
        .edgeBus (edgeBus)
    );

    // ------------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------------
    // write lands at the edge where the master sees ack high
    assign reqOn    = wb_cyc_i && wb_stb_i;
    assign wrCommit = reqOn && wb_we_i && (st_q.busSt == itc_pkg::ITC_BUS_ACK);
    assign wrOne    = wrCommit && (wb_adr_i == `ITC_ADR_CTRL_ONE);
    assign wrTwo    = wrCommit && (wb_adr_i == `ITC_ADR_CTRL_TWO);
    assign wrFlags  = wrCommit && (wb_adr_i == `ITC_ADR_FLAGS_ZERO);
    assign laneMask = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    assign wrData   = wb_dat_i[15:0];

    // ------------------------------------------------------------------
    // trap qualification
    // ------------------------------------------------------------------
    // disabled overflow is dropped here, no flag and no trap
    assign ovfATake = accAOvfEvt && st_q.ctrlOne[`ITC_C1_OVF_A_EN];
    assign ovfBTake = accBOvfEvt && st_q.ctrlOne[`ITC_C1_OVF_B_EN];
    assign catATake = accACatEvt && st_q.ctrlOne[`ITC_C1_CAT_EN];
    assign catBTake = accBCatEvt && st_q.ctrlOne[`ITC_C1_CAT_EN];
    assign mathTake = ovfATake || ovfBTake || catATake || catBTake ||
                      shiftErrEvt || divZeroEvt;

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    // software write first, hardware sets on top so a set is never lost
    always_comb begin
        st_d = st_q;

        // classic handshake: ack for one cycle, then drop
        case (st_q.busSt)
            itc_pkg::ITC_BUS_IDLE: begin
                if (reqOn) begin
                    st_d.busSt = itc_pkg::ITC_BUS_ACK;
                end
            end
            itc_pkg::ITC_BUS_ACK: begin
                st_d.busSt = itc_pkg::ITC_BUS_IDLE;
            end
            default: begin
                st_d.busSt = itc_pkg::ITC_BUS_IDLE;
            end
        endcase

        // read data prepared with ack; unmapped reads give zero
        st_d.rdData = `ITC_REG_RESET;
        if (reqOn && (st_q.busSt == itc_pkg::ITC_BUS_IDLE)) begin
            case (wb_adr_i)
                `ITC_ADR_CTRL_ONE:   st_d.rdData = st_q.ctrlOne & `ITC_C1_RD_MASK;
                `ITC_ADR_CTRL_TWO:   st_d.rdData = st_q.ctrlTwo & `ITC_C2_RD_MASK;
                `ITC_ADR_FLAGS_ZERO: st_d.rdData = st_q.flags & `ITC_FL_RD_MASK;
                default:             st_d.rdData = `ITC_REG_RESET;
            endcase
        end

        // software writes, per byte lane
        if (wrOne) begin
            st_d.ctrlOne = (st_q.ctrlOne & ~laneMask) | (wrData & laneMask);
        end
        if (wrTwo) begin
            st_d.ctrlTwo = (st_q.ctrlTwo & ~(laneMask & `ITC_C2_WR_MASK)) |
                           (wrData & laneMask & `ITC_C2_WR_MASK);
        end
        if (wrFlags) begin
            st_d.flags = (st_q.flags & ~laneMask) | (wrData & laneMask);
        end
        st_d.ctrlOne = st_d.ctrlOne & `ITC_C1_RD_MASK;
        st_d.flags   = st_d.flags & `ITC_FL_RD_MASK;

        // status bit mirrors the core, never written by software
        st_d.ctrlTwo[`ITC_C2_DIS_INSTR] = disableInstrActive;

        // trap status sets, sticky until cleared by software
        if (ovfATake) st_d.ctrlOne[`ITC_C1_OVF_A]     = 1'b1;
        if (ovfBTake) st_d.ctrlOne[`ITC_C1_OVF_B]     = 1'b1;
        if (catATake) st_d.ctrlOne[`ITC_C1_CAT_A]     = 1'b1;
        if (catBTake) st_d.ctrlOne[`ITC_C1_CAT_B]     = 1'b1;
        if (shiftErrEvt) st_d.ctrlOne[`ITC_C1_SHIFT_ERR] = 1'b1;
        if (divZeroEvt) st_d.ctrlOne[`ITC_C1_DIV_ZERO]   = 1'b1;
        if (dmaErrEvt) st_d.ctrlOne[`ITC_C1_DMA_ERR]     = 1'b1;
        if (mathTake) st_d.ctrlOne[`ITC_C1_MATH_ERR]     = 1'b1;
        if (addrErrEvt) st_d.ctrlOne[`ITC_C1_ADDR_ERR]   = 1'b1;
        if (stackErrEvt) st_d.ctrlOne[`ITC_C1_STACK_ERR] = 1'b1;
        if (oscFailEvt) st_d.ctrlOne[`ITC_C1_OSC_FAIL]   = 1'b1;

        // request flags: source sets, only software clears
        st_d.flags[14:1] = st_d.flags[14:1] | periphReq;
        st_d.flags[0]    = st_d.flags[0] | edgeBus.edgeSeen[0];

        // trap requests to the core, one cycle each
        st_d.mathTrap  = mathTake;
        st_d.addrTrap  = addrErrEvt;
        st_d.stackTrap = stackErrEvt;
        st_d.oscTrap   = oscFailEvt;
        st_d.dmaTrap   = dmaErrEvt;
        st_d.extEvent  = edgeBus.edgeSeen[2:1];

        // preemption only when nesting allowed or nothing in service
        st_d.preemptTake = pendReq && (pendLevel > cpuLevel) &&
            (!st_q.ctrlOne[`ITC_C1_NEST_DIS] || !inService);
    end

    // ------------------------------------------------------------------
    // state register
    // ------------------------------------------------------------------
    // everything clears to zero at power-on
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    // ------------------------------------------------------------------
    // outputs, all straight from flops
    // ------------------------------------------------------------------
    assign wb_dat_o             = {16'h0000, st_q.rdData};
    assign wb_ack_o             = (st_q.busSt == itc_pkg::ITC_BUS_ACK);
    assign mathTrap             = st_q.mathTrap;
    assign addrTrap             = st_q.addrTrap;
    assign stackTrap            = st_q.stackTrap;
    assign oscTrap              = st_q.oscTrap;
    assign dmaTrap              = st_q.dmaTrap;
    assign preemptTake          = st_q.preemptTake;
    assign nestingDisable       = st_q.ctrlOne[`ITC_C1_NEST_DIS];
    // core must refuse priority writes while this is high
    assign levelWriteLock       = st_q.ctrlOne[`ITC_C1_NEST_DIS];
    // vector fetch base chosen by the core from this level
    assign alternateTableSelect = st_q.ctrlTwo[`ITC_C2_ALT_TABLE];
    assign flagsZero            = st_q.flags;
    assign extEvent             = st_q.extEvent;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    sequence sNestBlocked;
        nestingDisable && inService;
    endsequence

    sequence sReadAck(logic [7:0] adr);
        wb_ack_o && !wb_we_i && (wb_adr_i == adr);
    endsequence

    AST_NEST_BLOCK: assert property (@(posedge clk) disable iff (!rstn)
        sNestBlocked |=> !preemptTake)
        else $error("preemption taken while nesting disabled");

    AST_OVF_A_SET: assert property (@(posedge clk) disable iff (!rstn)
        (accAOvfEvt && st_q.ctrlOne[`ITC_C1_OVF_A_EN]) |=>
            st_q.ctrlOne[`ITC_C1_OVF_A] && mathTrap)
        else $error("accumulator A overflow not flagged");

    AST_CAT_B_SET: assert property (@(posedge clk) disable iff (!rstn)
        (accBCatEvt && st_q.ctrlOne[`ITC_C1_CAT_EN]) |=> st_q.ctrlOne[`ITC_C1_CAT_B])
        else $error("accumulator B catastrophic overflow not flagged");

    AST_OVF_GATED: assert property (@(posedge clk) disable iff (!rstn)
        $rose(st_q.ctrlOne[`ITC_C1_OVF_B]) |->
            $past(accBOvfEvt && st_q.ctrlOne[`ITC_C1_OVF_B_EN]) || $past(wrOne))
        else $error("overflow flag set with its trap disabled");

    AST_CAT_GATED: assert property (@(posedge clk) disable iff (!rstn)
        (!st_q.ctrlOne[`ITC_C1_CAT_EN] && !shiftErrEvt && !divZeroEvt &&
         !ovfATake && !ovfBTake) |=> !mathTrap)
        else $error("math trap raised with catastrophic trap disabled");

    AST_MATH_ANY: assert property (@(posedge clk) disable iff (!rstn)
        (divZeroEvt || shiftErrEvt) |=> st_q.ctrlOne[`ITC_C1_MATH_ERR] ##1
            st_q.ctrlOne[`ITC_C1_MATH_ERR] || $past(wrOne))
        else $error("math error status missing after math trap");

    AST_ADDR_SET: assert property (@(posedge clk) disable iff (!rstn)
        addrErrEvt |=> addrTrap && st_q.ctrlOne[`ITC_C1_ADDR_ERR])
        else $error("address error trap not recorded");

    AST_UNIMPL_ONE: assert property (@(posedge clk) disable iff (!rstn)
        sReadAck(`ITC_ADR_CTRL_ONE) |-> (wb_dat_o[0] == 1'b0) && (wb_dat_o[31:16] == '0))
        else $error("unimplemented control one bit read as one");

    AST_UNIMPL_TWO: assert property (@(posedge clk) disable iff (!rstn)
        sReadAck(`ITC_ADR_CTRL_TWO) |-> (wb_dat_o[13:3] == '0))
        else $error("unimplemented control two bits read as one");

    AST_DIS_INSTR_RO: assert property (@(posedge clk) disable iff (!rstn)
        ##1 st_q.ctrlTwo[`ITC_C2_DIS_INSTR] == $past(disableInstrActive))
        else $error("disable instruction status does not follow the core");

    AST_FLAG_STICKY: assert property (@(posedge clk) disable iff (!rstn)
        (flagsZero[5] && !wrFlags) |=> flagsZero[5])
        else $error("request flag cleared without a software write");

    AST_TRAP_STICKY: assert property (@(posedge clk) disable iff (!rstn)
        (st_q.ctrlOne[`ITC_C1_STACK_ERR] && !wrOne) |=> st_q.ctrlOne[`ITC_C1_STACK_ERR])
        else $error("stack error status cleared by hardware");

    AST_PERIPH_SET: assert property (@(posedge clk) disable iff (!rstn)
        periphReq[14] |=> flagsZero[14])
        else $error("DMA channel 1 request not flagged");

    AST_OVF_B_SET: assert property (@(posedge clk) disable iff (!rstn)
        ovfBTake |=> st_q.ctrlOne[`ITC_C1_OVF_B] && mathTrap)
        else $error("accumulator B overflow not flagged");

    AST_CAT_A_SET: assert property (@(posedge clk) disable iff (!rstn)
        catATake |=> st_q.ctrlOne[`ITC_C1_CAT_A] && mathTrap)
        else $error("accumulator A catastrophic overflow not flagged");

    AST_SHIFT_SET: assert property (@(posedge clk) disable iff (!rstn)
        shiftErrEvt |=> st_q.ctrlOne[`ITC_C1_SHIFT_ERR] && mathTrap)
        else $error("shift error not flagged");

    AST_DIV_SET: assert property (@(posedge clk) disable iff (!rstn)
        divZeroEvt |=> st_q.ctrlOne[`ITC_C1_DIV_ZERO] && mathTrap)
        else $error("divide by zero not flagged");

    AST_DMA_SET: assert property (@(posedge clk) disable iff (!rstn)
        dmaErrEvt |=> dmaTrap && st_q.ctrlOne[`ITC_C1_DMA_ERR])
        else $error("DMA error trap not recorded");

    AST_STACK_SET: assert property (@(posedge clk) disable iff (!rstn)
        stackErrEvt |=> stackTrap && st_q.ctrlOne[`ITC_C1_STACK_ERR])
        else $error("stack error trap not recorded");

    AST_OSC_SET: assert property (@(posedge clk) disable iff (!rstn)
        oscFailEvt |=> oscTrap && st_q.ctrlOne[`ITC_C1_OSC_FAIL])
        else $error("oscillator failure trap not recorded");

    AST_UNIMPL_FLAGS: assert property (@(posedge clk) disable iff (!rstn)
        sReadAck(`ITC_ADR_FLAGS_ZERO) |-> !wb_dat_o[15])
        else $error("unimplemented flag bit read as one");

    AST_ALT_WRITE: assert property (@(posedge clk) disable iff (!rstn)
        (wrTwo && wb_sel_i[1]) |=> alternateTableSelect == $past(wb_dat_i[15]))
        else $error("alternate table select not written");

    AST_NEST_OPEN: assert property (@(posedge clk) disable iff (!rstn)
        (pendReq && (pendLevel > cpuLevel) && !nestingDisable) |=> preemptTake)
        else $error("higher level not allowed to nest");

    AST_BUS_ACK: assert property (@(posedge clk) disable iff (!rstn)
        (reqOn && !wb_ack_o) |=> wb_ack_o ##1 !wb_ack_o)
        else $error("ack not a single cycle after the request");
endmodule

/* testbench/itc_core_model.sv */
/*
 * Stand-in for the core and the requesting peripherals: turns one
 * command from the bench into single-cycle trap and request pulses.
 * Assumes the bench raises fire for exactly one cycle per command.
 */
module itc_core_model (
    input  wire logic        clk,
    input  wire logic        rstn,
    input  wire logic        fire,
    input  wire logic [9:0]  trapSel,
    input  wire logic [14:1] reqSel,
    output logic      [9:0]  trapEvt,
    output logic      [14:1] periphReq
);
    timeunit 1ns;
    timeprecision 1ps;
    // one-cycle pulses only; sources never clear the flags themselves
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            trapEvt   <= '0;
            periphReq <= '0;
        end else begin
            trapEvt   <= fire ? trapSel : '0;
            periphReq <= fire ? reqSel : '0;
        end
    end
endmodule

/* testbench/tb.sv */
/*
 * Self-checking bench for the interrupt and trap control block.
 * Assumes the register map header and a single 125 MHz clock.
 */
`include "itc_map.svh"
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, rstn, cyc, stb, we, ack, fire, disableInstrActive, pendReq, inService;
    logic clrSeen, preemptTake, nestingDisable, levelWriteLock, altSel;
    logic [7:0] adr;
    logic [3:0] sel, pendLevel, cpuLevel;
    logic [31:0] dat, datO;
    logic [9:0] trapSel, trapEvt;
    logic [14:1] reqSel, periphReq;
    logic [2:0] extPin;
    logic [4:0] trapO, trapSeen;
    logic [2:1] extEvent, seen;
    logic [15:0] flagsZero;
    int badCount = 0;
    int checkCount = 0;
    logic [15:0] trapExp [10] = '{16'h4010, 16'h2010, 16'h1010, 16'h0810, 16'h0090,
                                 16'h0050, 16'h0020, 16'h0008, 16'h0004, 16'h0002};
    itc_core_model core (.clk(clk), .rstn(rstn), .fire(fire), .trapSel(trapSel),
        .reqSel(reqSel), .trapEvt(trapEvt), .periphReq(periphReq));
    itc_top dut (.clk(clk), .rstn(rstn), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(datO), .wb_ack_o(ack),
        .accAOvfEvt(trapEvt[0]), .accBOvfEvt(trapEvt[1]), .accACatEvt(trapEvt[2]),
        .accBCatEvt(trapEvt[3]), .shiftErrEvt(trapEvt[4]), .divZeroEvt(trapEvt[5]),
        .dmaErrEvt(trapEvt[6]), .addrErrEvt(trapEvt[7]), .stackErrEvt(trapEvt[8]),
        .oscFailEvt(trapEvt[9]), .disableInstrActive(disableInstrActive),
        .periphReq(periphReq), .extPin(extPin), .pendReq(pendReq), .pendLevel(pendLevel),
        .cpuLevel(cpuLevel), .inService(inService), .mathTrap(trapO[0]), .dmaTrap(trapO[1]),
        .addrTrap(trapO[2]), .stackTrap(trapO[3]), .oscTrap(trapO[4]),
        .preemptTake(preemptTake), .nestingDisable(nestingDisable),
        .levelWriteLock(levelWriteLock), .alternateTableSelect(altSel),
        .flagsZero(flagsZero), .extEvent(extEvent));
    // ------------------------------------------------------------------
    // clock and edge-event catcher
    // ------------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    // extEvent is a single-cycle pulse, so latch it for a later look
    always @(posedge clk) seen <= clrSeen ? 2'b00 : (seen | extEvent);
    // trap pulses gathered since the last fire, which clears them
    always @(posedge clk) trapSeen <= fire ? 5'h00 : (trapSeen | trapO);
    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    task automatic check(input string name, input logic [15:0] got, input logic [15:0] exp);
        checkCount++;
        if (got !== exp) begin
            badCount++;
            $display("unexpected %s expected %h seen %h", name, exp, got);
        end
    endtask
    // classic single cycle; wait for ack with a bound, never a fixed count
    task automatic wb(input logic w, input logic [7:0] a, input logic [15:0] d,
                      output logic [15:0] q);
        int n;
        n = 0;
        @(posedge clk);
        cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; sel <= 4'h3; dat <= {16'h0000, d};
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 20);
        if (ack !== 1'b1) badCount++;
        q = datO[15:0];
        cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        logic [15:0] q;
        wb(1'b1, a, d, q);
    endtask
    task automatic rd(input string name, input logic [7:0] a, input logic [15:0] exp);
        logic [15:0] q;
        wb(1'b0, a, 16'h0000, q);
        check(name, q, exp);
    endtask
    task automatic pulse(input logic [9:0] t, input logic [14:1] r);
        @(posedge clk);
        fire <= 1'b1; trapSel <= t; reqSel <= r;
        @(posedge clk);
        fire <= 1'b0;
        repeat (4) @(posedge clk);
    endtask
    task automatic settle();
        repeat (2) @(posedge clk);
        #1;
    endtask
    task automatic summarize();
        if (badCount == 0 && checkCount > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // ------------------------------------------------------------------
    // watchdog and main sequence
    // ------------------------------------------------------------------
    initial begin
        repeat (20000) @(posedge clk);
        badCount++;
        summarize();
    end
    initial begin
        rstn = 0; cyc = 0; stb = 0; we = 0; adr = 0; sel = 0; dat = 0; fire = 0;
        trapSel = 0; reqSel = 0; disableInstrActive = 0; pendReq = 0; pendLevel = 0;
        cpuLevel = 0; inService = 0; extPin = 3'b010; clrSeen = 1;
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        rd("ctrlOne", `ITC_ADR_CTRL_ONE, 16'h0000);
        rd("ctrlTwo", `ITC_ADR_CTRL_TWO, 16'h0000);
        rd("flags", `ITC_ADR_FLAGS_ZERO, 16'h0000);
        rd("unmapped", 8'h0C, 16'h0000);
        wr(`ITC_ADR_CTRL_ONE, 16'hFFFF);
        rd("ctrlOne", `ITC_ADR_CTRL_ONE, 16'hFFFE);
        wr(`ITC_ADR_CTRL_TWO, 16'hFFFF);
        rd("ctrlTwo", `ITC_ADR_CTRL_TWO, 16'h8007);
        wr(`ITC_ADR_FLAGS_ZERO, 16'hFFFF);
        rd("flags", `ITC_ADR_FLAGS_ZERO, 16'h7FFF);
        @(posedge clk);
        pendReq <= 1'b1; pendLevel <= 4'h5; cpuLevel <= 4'h2; inService <= 1'b1;
        settle();
        check("nesting", 16'(nestingDisable), 16'h0001);
        check("levelLock", 16'(levelWriteLock), 16'h0001);
        check("altTable", 16'(altSel), 16'h0001);
        check("flagsOut", flagsZero, 16'h7FFF);
        check("preempt", 16'(preemptTake), 16'h0000);
        wr(`ITC_ADR_CTRL_ONE, 16'h0000);
        wr(`ITC_ADR_CTRL_TWO, 16'h0000);
        wr(`ITC_ADR_FLAGS_ZERO, 16'h0000);
        settle();
        check("preempt", 16'(preemptTake), 16'h0001);
        check("levelLock", 16'(levelWriteLock), 16'h0000);
        check("altTable", 16'(altSel), 16'h0000);
        // status bit follows the core, a write must not touch it
        @(posedge clk);
        disableInstrActive <= 1'b1;
        settle();
        wr(`ITC_ADR_CTRL_TWO, 16'h0000);
        rd("ctrlTwo", `ITC_ADR_CTRL_TWO, 16'h4000);
        @(posedge clk);
        disableInstrActive <= 1'b0;
        // overflow causes with their enables clear are dropped
        pulse(10'h00F, 14'h0000);
        rd("ctrlOne", `ITC_ADR_CTRL_ONE, 16'h0000);
        check("trapOff", 16'(trapSeen), 16'h0000);
        for (int i = 0; i < 10; i++) begin
            wr(`ITC_ADR_CTRL_ONE, 16'h0700);
            pulse(10'h001 << i, 14'h0000);
            repeat (20) @(posedge clk);
            rd("trap", `ITC_ADR_CTRL_ONE, 16'h0700 | trapExp[i]);
            check("trapOut", 16'(trapSeen), 16'((i < 6) ? 1 : (1 << (i - 5))));
        end
        wr(`ITC_ADR_CTRL_ONE, 16'h0000);
        rd("ctrlOne", `ITC_ADR_CTRL_ONE, 16'h0000);
        for (int i = 1; i < 15; i++) begin
            pulse(10'h000, 14'h0001 << (i - 1));
            rd("request", `ITC_ADR_FLAGS_ZERO, 16'h0001 << i);
            wr(`ITC_ADR_FLAGS_ZERO, 16'h0000);
        end
        // ext1 falling, ext0 and ext2 rising
        wr(`ITC_ADR_CTRL_TWO, 16'h0002);
        clrSeen <= 1'b0;
        extPin <= 3'b101;
        pulse(10'h000, 14'h0000);
        rd("ext0", `ITC_ADR_FLAGS_ZERO, 16'h0001);
        check("extEvent", 16'(seen), 16'h0003);
        wr(`ITC_ADR_FLAGS_ZERO, 16'h0000);
        @(posedge clk);
        clrSeen <= 1'b1;
        @(posedge clk);
        clrSeen <= 1'b0;
        extPin <= 3'b010;
        pulse(10'h000, 14'h0000);
        rd("ext0", `ITC_ADR_FLAGS_ZERO, 16'h0000);
        check("extEvent", 16'(seen), 16'h0000);
        summarize();
    end
endmodule
